//--- rtl/cc_core.sv
// Eight-bit processor core: datapath, cycle sequencer, stack and interrupts.
// Assumes memory answers a read within the same mclk cycle, on mclk.
`timescale 1ns/100ps
module cc_core (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] data_in,
  input wire logic nmi_n_in,
  input wire logic [7:0] irq_flag_in,
  input wire logic [7:0] irq_enable_in,
  input wire logic wide_mode_in,
  input wire logic [1:0] port_c_gen_in,
  output logic [12:0] addr_low_out,
  output logic addr_top_out,
  output logic port_c_line_six_out,
  output logic port_c_line_seven_out,
  output logic [7:0] data_out,
  output logic data_oe_n_out,
  output logic rw_out,
  output logic opcode_fetch_out,
  output logic [2:0] cycle_state_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  cc_pkg::cc_state_type state_q, state_d;
  logic [7:0] ir_q, ir_d;
  logic [15:0] pc_q, pc_d;
  logic [7:0] a_q, a_d, x_q, x_d, y_q, y_d;
  logic [7:0] sp_q, sp_d;
  logic [7:0] p_q, p_d;
  logic [7:0] lo_q, lo_d;
  logic [15:0] ea_q, ea_d;
  logic [15:0] vec_q, vec_d;
  logic int_q, int_d;
  logic [2:0] t_q, t_d;
  logic nmi_s1_q, nmi_s2_q, nmi_s3_q;
  logic nmi_pend_q, nmi_pend_d;
  logic [15:0] addr_q, addr_d;
  logic rw_q, rw_d;
  logic sync_q, sync_d;
  logic [7:0] dout_q, dout_d;
  logic [1:0] pcx_q, pcx_d;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction classes

  wire is_ld_imm = (ir_q == cc_pkg::OP_LDA_IMM) | (ir_q == cc_pkg::OP_LDX_IMM) |
                   (ir_q == cc_pkg::OP_LDY_IMM);
  wire is_alu_imm = (ir_q == cc_pkg::OP_ADC_IMM) | (ir_q == cc_pkg::OP_AND_IMM) |
                    (ir_q == cc_pkg::OP_ORA_IMM) | (ir_q == cc_pkg::OP_EOR_IMM);
  wire use_x = (ir_q == cc_pkg::OP_LDA_ABSX) | (ir_q == cc_pkg::OP_STA_ABSX);
  wire use_y = (ir_q == cc_pkg::OP_LDA_ABSY) | (ir_q == cc_pkg::OP_STA_ABSY);
  wire is_store = (ir_q == cc_pkg::OP_STA_ABS) | use_x & ir_q[4] & ~ir_q[5] |
                  (ir_q == cc_pkg::OP_STA_ABSX) | (ir_q == cc_pkg::OP_STA_ABSY);
  wire is_abs = use_x | use_y | is_store | (ir_q == cc_pkg::OP_LDA_ABS) |
                (ir_q == cc_pkg::OP_JMP) | (ir_q == cc_pkg::OP_JSR);
  wire is_push = (ir_q == cc_pkg::OP_PHA) | (ir_q == cc_pkg::OP_PHP);
  wire is_pull = (ir_q == cc_pkg::OP_PLA) | (ir_q == cc_pkg::OP_PLP) |
                 (ir_q == cc_pkg::OP_RTS) | (ir_q == cc_pkg::OP_RTI);
  wire [7:0] index = use_x ? x_q : (use_y ? y_q : 8'h00);

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt requests

  // Any enabled pending source holds the request up
  wire irq_req = |(irq_flag_in & irq_enable_in);
  // Third stage only feeds the edge compare, never the first stage
  wire nmi_fall = nmi_s3_q & ~nmi_s2_q;
  wire take_nmi = nmi_pend_q;
  wire take_irq = irq_req & ~p_q[cc_pkg::P_I];
  wire take_int = take_nmi | take_irq;

  // New edge in the clearing cycle is kept
  assign nmi_pend_d = nmi_fall |
                      (nmi_pend_q & ~((state_q == cc_pkg::ST_FETCH) & take_nmi));

  ////////////////////////////////////////////////////////////////////////////
  // ALU operand selection

  wire in_opnd = (state_q == cc_pkg::ST_OPND);
  wire xid = in_opnd & ((ir_q == cc_pkg::OP_INX) | (ir_q == cc_pkg::OP_DEX));
  wire yid = in_opnd & ((ir_q == cc_pkg::OP_INY) | (ir_q == cc_pkg::OP_DEY));
  wire push_st = (state_q == cc_pkg::ST_PSH_H) | (state_q == cc_pkg::ST_PSH_L) |
                 (state_q == cc_pkg::ST_PSH_P) | (state_q == cc_pkg::ST_PSH_R);
  wire sp_up = (state_q == cc_pkg::ST_SPINC) | (state_q == cc_pkg::ST_PUL_L) |
               ((state_q == cc_pkg::ST_PUL_R) & (ir_q == cc_pkg::OP_RTI));
  wire step_op = push_st | sp_up | xid | yid;
  wire dec_op = push_st | (in_opnd & ((ir_q == cc_pkg::OP_DEX) | (ir_q == cc_pkg::OP_DEY)));
  wire ld_path = (in_opnd & is_ld_imm) | (state_q == cc_pkg::ST_MEM) |
                 (state_q == cc_pkg::ST_PUL_R);

  logic [7:0] alu_a, alu_b, alu_y;
  logic alu_c, alu_co, alu_ov, alu_zr, alu_ng;
  cc_pkg::cc_alu_op_type alu_op;

  // Steps use a zero or all-ones constant operand
  assign alu_a = (push_st | sp_up) ? sp_q : xid ? x_q : yid ? y_q :
                 ld_path ? 8'h00 : a_q;
  assign alu_b = step_op ? (dec_op ? 8'hff : 8'h00) : data_in;
  assign alu_c = step_op ? ~dec_op :
                 (in_opnd & (ir_q == cc_pkg::OP_ADC_IMM) & p_q[cc_pkg::P_C]);
  assign alu_op = (step_op | ~in_opnd | is_ld_imm) ? (ld_path & ~step_op ?
                  cc_pkg::ALU_OR : cc_pkg::ALU_ADD) :
                  (ir_q == cc_pkg::OP_AND_IMM) ? cc_pkg::ALU_AND :
                  (ir_q == cc_pkg::OP_ORA_IMM) ? cc_pkg::ALU_OR :
                  (ir_q == cc_pkg::OP_EOR_IMM) ? cc_pkg::ALU_XOR : cc_pkg::ALU_ADD;

  cc_alu #(
    .WIDTH(8)
  ) u_alu (
    .opa_in(alu_a),
    .opb_in(alu_b),
    .carry_in(alu_c),
    .op_in(alu_op),
    .result_out(alu_y),
    .carry_out(alu_co),
    .overflow_out(alu_ov),
    .zero_out(alu_zr),
    .negative_out(alu_ng)
  );

  // Status byte as pushed; break bit only for software sources
  wire [7:0] push_p = p_q | (8'h01 << cc_pkg::P_U) |
                      (int_q ? 8'h00 : (8'h01 << cc_pkg::P_B));
  // Status byte as pulled; break bit is not a stored flag
  wire [7:0] pull_p = (data_in | (8'h01 << cc_pkg::P_U)) & ~(8'h01 << cc_pkg::P_B);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: decides the next bus cycle from this one

  always_comb begin
    state_d = state_q;
    ir_d = ir_q;
    pc_d = pc_q;
    a_d = a_q;
    x_d = x_q;
    y_d = y_q;
    sp_d = sp_q;
    p_d = p_q;
    lo_d = lo_q;
    ea_d = ea_q;
    vec_d = vec_q;
    int_d = int_q;
    case (state_q)
      cc_pkg::ST_VLO: begin
        pc_d[7:0] = data_in;
        state_d = cc_pkg::ST_VHI;
      end
      cc_pkg::ST_VHI: begin
        pc_d[15:8] = data_in;
        state_d = cc_pkg::ST_FETCH;
      end
      cc_pkg::ST_FETCH: begin
        if (take_int) begin
          // Fetched byte dropped; entry reuses the break sequence
          ir_d = cc_pkg::OP_BRK;
          int_d = 1'b1;
          vec_d = take_nmi ? cc_pkg::NMI_VEC : cc_pkg::IRQ_VEC;
          state_d = cc_pkg::ST_PSH_H;
        end else begin
          ir_d = data_in;
          int_d = 1'b0;
          pc_d = pc_q + 16'h0001;
          state_d = cc_pkg::ST_OPND;
        end
      end
      cc_pkg::ST_OPND: begin
        // Second cycle always reads the byte after the opcode
        state_d = cc_pkg::ST_FETCH;
        if (is_ld_imm | is_alu_imm) begin
          pc_d = pc_q + 16'h0001;
          p_d[cc_pkg::P_N] = alu_ng;
          p_d[cc_pkg::P_Z] = alu_zr;
          if (ir_q == cc_pkg::OP_LDX_IMM) begin
            x_d = alu_y;
          end else if (ir_q == cc_pkg::OP_LDY_IMM) begin
            y_d = alu_y;
          end else begin
            a_d = alu_y;
          end
          if (ir_q == cc_pkg::OP_ADC_IMM) begin
            p_d[cc_pkg::P_C] = alu_co;
            p_d[cc_pkg::P_V] = alu_ov;
          end
        end else if (is_abs) begin
          lo_d = data_in;
          pc_d = pc_q + 16'h0001;
          state_d = cc_pkg::ST_ADH;
        end else if (is_push) begin
          state_d = cc_pkg::ST_PSH_R;
        end else if (is_pull) begin
          state_d = cc_pkg::ST_SPINC;
        end else if (ir_q == cc_pkg::OP_BRK) begin
          if (!int_q) begin
            pc_d = pc_q + 16'h0001;
            vec_d = cc_pkg::IRQ_VEC;
          end
          state_d = cc_pkg::ST_PSH_H;
        end else if (xid | yid) begin
          if (xid) begin
            x_d = alu_y;
          end else begin
            y_d = alu_y;
          end
          p_d[cc_pkg::P_N] = alu_ng;
          p_d[cc_pkg::P_Z] = alu_zr;
        end else if (ir_q == cc_pkg::OP_TXS) begin
          sp_d = x_q;
        end else if (ir_q == cc_pkg::OP_SEI) begin
          p_d[cc_pkg::P_I] = 1'b1;
        end else if (ir_q == cc_pkg::OP_CLI) begin
          p_d[cc_pkg::P_I] = 1'b0;
        end
      end
      cc_pkg::ST_ADH: begin
        pc_d = pc_q + 16'h0001;
        ea_d = {data_in, lo_q} + {8'h00, index};
        if (ir_q == cc_pkg::OP_JMP) begin
          pc_d = {data_in, lo_q};
          state_d = cc_pkg::ST_FETCH;
        end else if (ir_q == cc_pkg::OP_JSR) begin
          state_d = cc_pkg::ST_PSH_H;
        end else begin
          state_d = cc_pkg::ST_MEM;
        end
      end
      cc_pkg::ST_MEM: begin
        if (!is_store) begin
          a_d = alu_y;
          p_d[cc_pkg::P_N] = alu_ng;
          p_d[cc_pkg::P_Z] = alu_zr;
        end
        state_d = cc_pkg::ST_FETCH;
      end
      cc_pkg::ST_PSH_H: begin
        sp_d = alu_y;
        state_d = cc_pkg::ST_PSH_L;
      end
      cc_pkg::ST_PSH_L: begin
        sp_d = alu_y;
        if (ir_q == cc_pkg::OP_JSR) begin
          pc_d = ea_q;
          state_d = cc_pkg::ST_FETCH;
        end else begin
          state_d = cc_pkg::ST_PSH_P;
        end
      end
      cc_pkg::ST_PSH_P: begin
        sp_d = alu_y;
        p_d[cc_pkg::P_I] = 1'b1;
        state_d = cc_pkg::ST_VLO;
      end
      cc_pkg::ST_PSH_R: begin
        sp_d = alu_y;
        state_d = cc_pkg::ST_FETCH;
      end
      cc_pkg::ST_SPINC: begin
        sp_d = alu_y;
        state_d = (ir_q == cc_pkg::OP_RTS) ? cc_pkg::ST_PUL_L : cc_pkg::ST_PUL_R;
      end
      cc_pkg::ST_PUL_R: begin
        state_d = cc_pkg::ST_FETCH;
        if (ir_q == cc_pkg::OP_PLA) begin
          a_d = alu_y;
          p_d[cc_pkg::P_N] = alu_ng;
          p_d[cc_pkg::P_Z] = alu_zr;
        end else begin
          p_d = pull_p;
        end
        if (ir_q == cc_pkg::OP_RTI) begin
          sp_d = alu_y;
          state_d = cc_pkg::ST_PUL_L;
        end
      end
      cc_pkg::ST_PUL_L: begin
        pc_d[7:0] = data_in;
        sp_d = alu_y;
        state_d = cc_pkg::ST_PUL_H;
      end
      cc_pkg::ST_PUL_H: begin
        pc_d[15:8] = data_in;
        state_d = cc_pkg::ST_FETCH;
      end
      default: begin
        state_d = cc_pkg::ST_FETCH;
      end
    endcase
  end

  // Cycle counter restarts with every opcode fetch
  assign t_d = (state_d == cc_pkg::ST_FETCH) ? cc_pkg::T_FIRST : t_q + 3'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Next bus cycle, registered so every pin comes from a flop

  wire stk_d = (state_d == cc_pkg::ST_PSH_H) | (state_d == cc_pkg::ST_PSH_L) |
               (state_d == cc_pkg::ST_PSH_P) | (state_d == cc_pkg::ST_PSH_R) |
               (state_d == cc_pkg::ST_PUL_R) | (state_d == cc_pkg::ST_PUL_L) |
               (state_d == cc_pkg::ST_PUL_H);
  wire wr_d = (state_d == cc_pkg::ST_PSH_H) | (state_d == cc_pkg::ST_PSH_L) |
              (state_d == cc_pkg::ST_PSH_P) | (state_d == cc_pkg::ST_PSH_R) |
              ((state_d == cc_pkg::ST_MEM) & is_store);

  assign addr_d = (state_d == cc_pkg::ST_MEM) ? ea_d :
                  stk_d ? {cc_pkg::STACK_PAGE, sp_d} :
                  (state_d == cc_pkg::ST_VLO) ? vec_d :
                  (state_d == cc_pkg::ST_VHI) ? (vec_d | 16'h0001) :
                  pc_d;
  assign rw_d = ~wr_d;
  assign sync_d = (state_d == cc_pkg::ST_FETCH);
  assign dout_d = (state_d == cc_pkg::ST_PSH_H) ? pc_d[15:8] :
                  (state_d == cc_pkg::ST_PSH_L) ? pc_d[7:0] :
                  (state_d == cc_pkg::ST_PSH_P) ? push_p :
                  ((state_d == cc_pkg::ST_PSH_R) & (ir_q == cc_pkg::OP_PHP)) ? push_p :
                  a_q;
  // Port C lines fall back to port logic outside wide mode
  assign pcx_d = wide_mode_in ? addr_d[14:13] : port_c_gen_in;

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  // Control and visible registers; reset fetches from the reset vector
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      state_q <= cc_pkg::ST_VLO;
      vec_q <= cc_pkg::RESET_VEC;
      addr_q <= cc_pkg::RESET_VEC;
      ir_q <= 8'h00;
      pc_q <= 16'h0000;
      a_q <= 8'h00;
      x_q <= 8'h00;
      y_q <= 8'h00;
      p_q <= cc_pkg::P_RESET;
      lo_q <= 8'h00;
      ea_q <= 16'h0000;
      int_q <= 1'b0;
      t_q <= cc_pkg::T_FIRST;
      nmi_pend_q <= 1'b0;
      rw_q <= 1'b1;
      sync_q <= 1'b0;
      dout_q <= 8'h00;
      pcx_q <= cc_pkg::RESET_VEC[14:13];
    end else begin
      state_q <= state_d;
      vec_q <= vec_d;
      addr_q <= addr_d;
      ir_q <= ir_d;
      pc_q <= pc_d;
      a_q <= a_d;
      x_q <= x_d;
      y_q <= y_d;
      p_q <= p_d;
      lo_q <= lo_d;
      ea_q <= ea_d;
      int_q <= int_d;
      t_q <= t_d;
      nmi_pend_q <= nmi_pend_d;
      rw_q <= rw_d;
      sync_q <= sync_d;
      dout_q <= dout_d;
      pcx_q <= pcx_d;
    end
  end

  // Stack pointer has no reset value; software must load it first
  always_ff @(posedge mclk_in) begin
    sp_q <= sp_d;
  end

  // Pin synchroniser, idle high; reset avoids a false edge at release
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      nmi_s1_q <= 1'b1;
      nmi_s2_q <= 1'b1;
      nmi_s3_q <= 1'b1;
    end else begin
      nmi_s1_q <= nmi_n_in;
      nmi_s2_q <= nmi_s1_q;
      nmi_s3_q <= nmi_s2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins

  assign addr_low_out = addr_q[12:0];
  assign addr_top_out = addr_q[15];
  assign port_c_line_six_out = pcx_q[0];
  assign port_c_line_seven_out = pcx_q[1];
  assign data_out = dout_q;
  assign data_oe_n_out = rw_q;
  assign rw_out = rw_q;
  assign opcode_fetch_out = sync_q;
  assign cycle_state_out = t_q;

endmodule

//--- rtl/cc_pkg.sv
// Shared constants and types for the processor core and its ALU.
// Assumes one clock domain; every user writes cc_pkg::name.
package cc_pkg;

  // Vectors and stack page
  localparam logic [15:0] RESET_VEC = 16'hfffc;
  localparam logic [15:0] NMI_VEC = 16'hfffa;
  localparam logic [15:0] IRQ_VEC = 16'hfffe;
  localparam logic [7:0] STACK_PAGE = 8'h00;

  // Status bit positions
  localparam int P_C = 0;
  localparam int P_Z = 1;
  localparam int P_I = 2;
  localparam int P_B = 4;
  localparam int P_U = 5;
  localparam int P_V = 6;
  localparam int P_N = 7;

  // Values after reset; number of maskable interrupt sources
  localparam logic [7:0] P_RESET = 8'h24;
  localparam logic [2:0] T_FIRST = 3'h0;
  localparam int IRQ_SOURCES = 8;

  // Supported operation codes
  localparam logic [7:0] OP_BRK = 8'h00;
  localparam logic [7:0] OP_PHP = 8'h08;
  localparam logic [7:0] OP_ORA_IMM = 8'h09;
  localparam logic [7:0] OP_JSR = 8'h20;
  localparam logic [7:0] OP_PLP = 8'h28;
  localparam logic [7:0] OP_AND_IMM = 8'h29;
  localparam logic [7:0] OP_RTI = 8'h40;
  localparam logic [7:0] OP_PHA = 8'h48;
  localparam logic [7:0] OP_EOR_IMM = 8'h49;
  localparam logic [7:0] OP_JMP = 8'h4c;
  localparam logic [7:0] OP_CLI = 8'h58;
  localparam logic [7:0] OP_RTS = 8'h60;
  localparam logic [7:0] OP_PLA = 8'h68;
  localparam logic [7:0] OP_ADC_IMM = 8'h69;
  localparam logic [7:0] OP_SEI = 8'h78;
  localparam logic [7:0] OP_DEY = 8'h88;
  localparam logic [7:0] OP_STA_ABS = 8'h8d;
  localparam logic [7:0] OP_STA_ABSY = 8'h99;
  localparam logic [7:0] OP_TXS = 8'h9a;
  localparam logic [7:0] OP_STA_ABSX = 8'h9d;
  localparam logic [7:0] OP_LDY_IMM = 8'ha0;
  localparam logic [7:0] OP_LDX_IMM = 8'ha2;
  localparam logic [7:0] OP_LDA_IMM = 8'ha9;
  localparam logic [7:0] OP_LDA_ABS = 8'had;
  localparam logic [7:0] OP_LDA_ABSY = 8'hb9;
  localparam logic [7:0] OP_LDA_ABSX = 8'hbd;
  localparam logic [7:0] OP_INY = 8'hc8;
  localparam logic [7:0] OP_DEX = 8'hca;
  localparam logic [7:0] OP_INX = 8'he8;

  // Bus cycle states, one per bus cycle
  typedef enum logic [3:0] {
    ST_VLO = 4'h0,
    ST_VHI = 4'h1,
    ST_FETCH = 4'h2,
    ST_OPND = 4'h3,
    ST_ADH = 4'h4,
    ST_MEM = 4'h5,
    ST_PSH_H = 4'h6,
    ST_PSH_L = 4'h7,
    ST_PSH_P = 4'h8,
    ST_PSH_R = 4'h9,
    ST_SPINC = 4'ha,
    ST_PUL_R = 4'hb,
    ST_PUL_L = 4'hc,
    ST_PUL_H = 4'hd
  } cc_state_type;

  typedef enum logic [1:0] {
    ALU_ADD = 2'h0,
    ALU_AND = 2'h1,
    ALU_OR = 2'h2,
    ALU_XOR = 2'h3
  } cc_alu_op_type;

endpackage

//--- rtl/cc_alu.sv
// Combinational ALU: add with carry, and, or, xor, plus flag outputs.
// Assumes the caller captures the result at the next clock edge.
`timescale 1ns/100ps
module cc_alu #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] opa_in,
  input wire logic [WIDTH-1:0] opb_in,
  input wire logic carry_in,
  input wire cc_pkg::cc_alu_op_type op_in,
  output logic [WIDTH-1:0] result_out,
  output logic carry_out,
  output logic overflow_out,
  output logic zero_out,
  output logic negative_out
);

  logic [WIDTH:0] sum;

  // Sum kept one bit wider for the carry
  assign sum = {1'b0, opa_in} + {1'b0, opb_in} + {{WIDTH{1'b0}}, carry_in};

  // Function select; no storage, result is gone after this cycle
  assign result_out = (op_in == cc_pkg::ALU_AND) ? (opa_in & opb_in) :
                      (op_in == cc_pkg::ALU_OR) ? (opa_in | opb_in) :
                      (op_in == cc_pkg::ALU_XOR) ? (opa_in ^ opb_in) :
                      sum[WIDTH-1:0];

  // Flags; overflow only meaningful for the add
  assign carry_out = sum[WIDTH];
  assign overflow_out = (opa_in[WIDTH-1] == opb_in[WIDTH-1]) &&
                        (sum[WIDTH-1] != opa_in[WIDTH-1]);
  assign zero_out = (result_out == '0);
  assign negative_out = result_out[WIDTH-1];

endmodule

//--- test/cc_core_asserts.sv
// Bus-level checks for cc_core, attached to every instance by bind.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/100ps
module cc_core_asserts (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic wide_mode_in,
  input wire logic [1:0] port_c_gen_in,
  input wire logic [12:0] addr_low_out,
  input wire logic addr_top_out,
  input wire logic port_c_line_six_out,
  input wire logic port_c_line_seven_out,
  input wire logic data_oe_n_out,
  input wire logic rw_out,
  input wire logic opcode_fetch_out,
  input wire logic [2:0] cycle_state_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  logic pz;
  // Page-zero access; only stack traffic lands there in practice
  assign pz = !addr_top_out && addr_low_out[12:8] == 5'h00;
  ////////////////////////////////////////////////////////////////////////////////
  a_reset_vector:
    assert property ($rose(rst_n_in) |-> addr_low_out == 13'h1ffc && addr_top_out
      && (!wide_mode_in || port_c_line_six_out && port_c_line_seven_out)
      ##1 addr_low_out == 13'h1ffd && rw_out ##1 opcode_fetch_out)
    else $error("reset vector sequence wrong");
  a_fetch_first_state:
    assert property (opcode_fetch_out |-> cycle_state_out == 3'h0)
    else $error("fetch cycle not in first state");
  a_state_advance:
    assert property (opcode_fetch_out |=> cycle_state_out == 3'h1)
    else $error("cycle state did not advance");
  a_oe_follows_rw:
    assert property ((data_oe_n_out == rw_out) and (!rw_out [*3] |=> rw_out))
    else $error("data enable or write run length wrong");
  a_fetch_is_read:
    assert property (opcode_fetch_out |-> rw_out)
    else $error("opcode fetch marked on a write");
  a_push_decrement:
    assert property ((!rw_out && pz) ##1 (!rw_out && pz)
      |-> addr_low_out[7:0] == $past(addr_low_out[7:0]) - 8'h01)
    else $error("push address did not step down by one");
  a_pull_increment:
    assert property ((rw_out && pz) ##1 (rw_out && pz)
      |-> addr_low_out[7:0] == $past(addr_low_out[7:0]) + 8'h01)
    else $error("pull address did not step up by one");
  a_port_c_general:
    assert property (!$past(wide_mode_in) |-> port_c_line_six_out == $past(port_c_gen_in[0])
      && port_c_line_seven_out == $past(port_c_gen_in[1]))
    else $error("port C lines do not follow general value");
  a_entry_vector:
    assert property ((!rw_out && pz) [*3] |=> rw_out && addr_top_out
      && (addr_low_out == 13'h1ffa || addr_low_out == 13'h1ffe))
    else $error("no vector read after three pushes");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind cc_core cc_core_asserts cc_core_asserts_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
  .wide_mode_in(wide_mode_in), .port_c_gen_in(port_c_gen_in), .addr_low_out(addr_low_out),
  .addr_top_out(addr_top_out), .port_c_line_six_out(port_c_line_six_out),
  .port_c_line_seven_out(port_c_line_seven_out), .data_oe_n_out(data_oe_n_out),
  .rw_out(rw_out), .opcode_fetch_out(opcode_fetch_out), .cycle_state_out(cycle_state_out));

//--- test/cc_mem.sv
// Behavioural external memory on the core's parallel bus.
// Assumes reads answer in the same mclk cycle; no wait states exist.
`timescale 1ns/100ps
module cc_mem (
  input wire logic clk_in,
  input wire logic [15:0] addr_in,
  input wire logic rw_in,
  input wire logic oe_n_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out
);
  logic [7:0] mem [0:65535];
  logic [7:0] junk_q = 8'h00;
  // Unwritten space reads as a two-cycle filler operation
  initial foreach (mem[i]) mem[i] = 8'hea;
  // Released bus moves every cycle so stale data cannot pass for a read
  assign rdata_out = rw_in ? mem[addr_in] : junk_q;
  always @(posedge clk_in) begin
    junk_q <= junk_q + 8'h3b;
    if (!rw_in && !oe_n_in) mem[addr_in] <= wdata_in;
  end
endmodule

//--- test/tb_cc_core.sv
// Bench: runs a short program on the core and checks every write in order.
// Assumes cc_mem answers reads combinationally; expectations built here.
`timescale 1ns/100ps
module tb_cc_core;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic nmi_n_in = 1'b1;
  logic wide_mode_in = 1'b1;
  logic [1:0] port_c_gen_in = 2'h0;
  logic [7:0] irq_flag_in = 8'h00;
  logic [7:0] irq_enable_in = 8'h00;
  logic [7:0] data_in, data_out, r, st, a4, ps;
  logic [12:0] addr_low_out;
  logic [2:0] cycle_state_out;
  logic addr_top_out, port_c_line_six_out, port_c_line_seven_out;
  logic data_oe_n_out, rw_out, opcode_fetch_out;
  logic [15:0] addr;
  logic [23:0] exp_q[$];
  int errors = 0;
  int n_checks = 0;

  initial forever #5 mclk_in = ~mclk_in;
  // Bits 13 and 14 reach memory only in wide mode
  assign addr = {addr_top_out, wide_mode_in ? {port_c_line_seven_out, port_c_line_six_out}
    : 2'h0, addr_low_out};
  cc_core cc_core_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .data_in(data_in),
    .nmi_n_in(nmi_n_in), .irq_flag_in(irq_flag_in), .irq_enable_in(irq_enable_in),
    .wide_mode_in(wide_mode_in), .port_c_gen_in(port_c_gen_in), .addr_low_out(addr_low_out),
    .addr_top_out(addr_top_out), .port_c_line_six_out(port_c_line_six_out),
    .port_c_line_seven_out(port_c_line_seven_out), .data_out(data_out),
    .data_oe_n_out(data_oe_n_out), .rw_out(rw_out), .opcode_fetch_out(opcode_fetch_out),
    .cycle_state_out(cycle_state_out));
  cc_mem cc_mem_i (.clk_in(mclk_in), .addr_in(addr), .rw_in(rw_out), .oe_n_in(data_oe_n_out),
    .wdata_in(data_out), .rdata_out(data_in));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    if (errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] want);
    n_checks++;
    if (got !== want) begin
      errors++;
      $display("FAIL %0t got 0x%h want 0x%h", $time, got, want);
    end
  endtask
  task automatic ex(input logic [15:0] a, input logic [7:0] d);
    exp_q.push_back({a, d});
  endtask
  task automatic put(input logic [15:0] a, input logic [63:0] v);
    for (int k = 0; k < 8; k++) cc_mem_i.mem[a + 16'(k)] = v[8*(7-k) +: 8];
  endtask
  // Bounded wait for all expected writes; a stall ends the run
  task automatic drain();
    for (int k = 0; k < 400 && exp_q.size() != 0; k++) @(negedge mclk_in);
    if (exp_q.size() != 0) begin
      chk(exp_q[0], 24'h000000);
      results();
    end
  endtask
  // Writes of the main program, in bus order
  task automatic prog();
    ex(16'h0303, r);
    ex(16'h00ff, r);
    ex(16'h00fe, 8'h02);
    ex(16'h00fd, 8'h0e);
    ex(16'h00fc, ps);
    ex(16'h0701, a4);
    ex(16'h0800, r);
    ex(16'h0400, r);
  endtask
  // Interrupt entry taken at the loop fetch, then the handler's store
  task automatic frame(input logic [15:0] h);
    ex(16'h00ff, 8'h02);
    ex(16'h00fe, 8'h13);
    ex(16'h00fd, st);
    ex(h, r);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Each write cycle is one result of the model
  always @(negedge mclk_in) begin
    if (rst_n_in === 1'b1 && rw_out === 1'b0) begin
      if (exp_q.size() == 0) chk({addr, data_out}, 24'hxxxxxx);
      else chk({addr, data_out}, exp_q.pop_front());
    end
  end
  initial begin
    r = 8'($urandom(32'hd08b));
    // Add, xor, or, and chain; carry and overflow of r plus one stay in status
    a4 = (~(r + 8'h01) | 8'h01) & 8'h7f;
    ps = 8'h34 | ((r == 8'hff) ? 8'h01 : 8'h00) | ((r == 8'h7f) ? 8'h40 : 8'h00);
    st = 8'h20 | (r & 8'h80) | ((r == 8'h00) ? 8'h02 : 8'h00) | (ps & 8'h41);
    @(negedge mclk_in);
    // Vectors, handlers, main program
    put(16'hfff8, 64'h0000_8001_0002_8401);
    put(16'h0180, 64'h8d00_0540_8d00_0640);
    put(16'h0200, 64'ha2ff_9aa9_00a2_039d);
    put(16'h0208, 64'h0003_4820_8002_688d);
    put(16'h0210, 64'h0004_584c_1302_eaea);
    cc_mem_i.mem[16'h0204] = r;
    // Subroutine: immediate ALU ops, status push and pull, index steps
    put(16'h0280, 64'h6901_49ff_0901_297f);
    put(16'h0288, 64'h08c8_c888_9900_07e8);
    put(16'h0290, 64'he8ca_bdff_028d_0008);
    put(16'h0298, 64'h2878_60ea_eaea_eaea);
    repeat (7) @(negedge mclk_in);
    rst_n_in = 1'b1;
    prog();
    drain();
    nmi_n_in = 1'b0;
    frame(16'h0500);
    drain();
    // New fall and a maskable request both wait for the handler's return
    nmi_n_in = 1'b1;
    @(negedge mclk_in);
    nmi_n_in = 1'b0;
    irq_flag_in = 8'h01;
    irq_enable_in = 8'h01;
    frame(16'h0500);
    frame(16'h0600);
    drain();
    irq_flag_in = 8'h00;
    nmi_n_in = 1'b1;
    @(negedge mclk_in);
    // Each maskable source alone; the last held pending for two entries
    for (int i = 0; i < 8; i++) begin
      irq_enable_in = 8'($urandom) | (8'h01 << i);
      irq_flag_in = 8'h01 << i;
      frame(16'h0600);
      if (i == 7) frame(16'h0600);
      drain();
      irq_flag_in = 8'h00;
      @(negedge mclk_in);
    end
    // Pending flags with no enable must stay quiet
    irq_flag_in = 8'($urandom) | 8'h01;
    irq_enable_in = ~irq_flag_in;
    repeat (40) @(negedge mclk_in);
    irq_flag_in = 8'h00;
    rst_n_in = 1'b0;
    repeat (8) @(negedge mclk_in);
    rst_n_in = 1'b1;
    prog();
    drain();
    wide_mode_in = 1'b0;
    for (int i = 0; i < 8; i++) begin
      port_c_gen_in = 2'($urandom);
      @(negedge mclk_in);
      chk({22'h0, port_c_line_seven_out, port_c_line_six_out}, {22'h0, port_c_gen_in});
    end
    results();
  end
endmodule
